// ==== logic/sms_controller.sv ====
`timescale 1ns/1ns
module sms_controller (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // link to device
    sms_link_if.controller LINK
);

    typedef struct packed {
        logic sel;
        logic clk_det;
        logic radio_cmd;
        logic wake_en;
        logic rise_en;
        logic fall_en;
        logic [2:0] pvd_level;
        logic [2:0] bor_level;
        sms_pkg::sms_cpu_mode_type cpu_mode;
        sms_pkg::sms_radio_mode_type radio_mode;
        logic inrush_wr;
        logic [1:0] inrush_data;
        logic [2:0] events;
        logic [31:0] rdata;
        logic err;
    } sms_ctl_state_type;

    sms_ctl_state_type st;
    sms_ctl_state_type next_st;

    logic setup;
    logic wr;
    logic hit;

    // ==========================================================
    // register access
    always_comb
    begin
        next_st = st;
        next_st.inrush_wr = 1'b0;
        setup = PSEL_I && !PENABLE_I;
        wr = PSEL_I && PENABLE_I && PWRITE_I;
        hit = (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_FIVE) ||
              (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_THREE) ||
              (PADDR_I == sms_pkg::ADDR_MODE) ||
              (PADDR_I == sms_pkg::ADDR_INRUSH) ||
              (PADDR_I == sms_pkg::ADDR_STATUS) ||
              (PADDR_I == sms_pkg::ADDR_EVENT);
        if (setup)
        begin
            next_st.err = !hit;
            next_st.rdata = 32'h0000_0000;
            if (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_FIVE)
                next_st.rdata[2:0] = {st.radio_cmd, st.clk_det, st.sel};
            else if (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_THREE)
                next_st.rdata[10:0] = {st.bor_level, 1'b0, st.pvd_level, 1'b0,
                                       st.fall_en, st.rise_en, st.wake_en};
            else if (PADDR_I == sms_pkg::ADDR_MODE)
                next_st.rdata[6:0] = {st.radio_mode, 1'b0, st.cpu_mode};
            else if (PADDR_I == sms_pkg::ADDR_INRUSH)
                next_st.rdata[1:0] = LINK.inrush_value;
            else if (PADDR_I == sms_pkg::ADDR_STATUS)
                next_st.rdata[5:0] = {LINK.end_of_life_level, LINK.pvm_ok, LINK.bor_reset,
                                      LINK.smps_on, LINK.ldo_on, LINK.smps_active_flag};
            else if (PADDR_I == sms_pkg::ADDR_EVENT)
                next_st.rdata[2:0] = st.events;
        end
        if (wr)
        begin
            if (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_FIVE)
                {next_st.radio_cmd, next_st.clk_det, next_st.sel} = PWDATA_I[2:0];
            else if (PADDR_I == sms_pkg::ADDR_POWER_CONTROL_THREE)
            begin
                {next_st.fall_en, next_st.rise_en, next_st.wake_en} = PWDATA_I[2:0];
                next_st.pvd_level = PWDATA_I[6:4];
                next_st.bor_level = PWDATA_I[10:8];
            end
            else if (PADDR_I == sms_pkg::ADDR_MODE)
            begin
                next_st.cpu_mode = sms_pkg::sms_cpu_mode_type'(PWDATA_I[2:0]);
                next_st.radio_mode = sms_pkg::sms_radio_mode_type'(PWDATA_I[6:4]);
            end
            else if (PADDR_I == sms_pkg::ADDR_INRUSH)
            begin
                next_st.inrush_wr = 1'b1;
                next_st.inrush_data = PWDATA_I[1:0];
            end
            else if (PADDR_I == sms_pkg::ADDR_EVENT)
                next_st.events = st.events & ~PWDATA_I[2:0];
        end
        // sticky events; a new event wins over its clear
        next_st.events = next_st.events |
            {LINK.end_of_life_level, LINK.pvd_wake, LINK.pvd_irq};
        // end of life forces the radio out of busy modes
        if (LINK.end_of_life_level && ((next_st.radio_mode == sms_pkg::RAD_ACTIVE) ||
                         (next_st.radio_mode == sms_pkg::RAD_STANDBY_XTAL)))
            next_st.radio_mode = sms_pkg::RAD_SLEEP;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st <= '0;
            st.clk_det <= 1'b0;
            st.cpu_mode <= sms_pkg::CPU_RUN;
            st.radio_mode <= sms_pkg::RAD_SLEEP;
        end
        else
            st <= next_st;
    end

    // ==========================================================
    // outputs
    assign PRDATA_O = st.rdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && st.err;
    assign LINK.cpu_select = st.sel;
    assign LINK.clk_detect_en = st.clk_det;
    assign LINK.radio_smps_cmd = st.radio_cmd;
    assign LINK.cpu_mode = st.cpu_mode;
    assign LINK.radio_mode = st.radio_mode;
    // one bit enables detector and its wakeup together
    assign LINK.pvd_enable = st.wake_en;
    assign LINK.pvd_level = st.pvd_level;
    assign LINK.pvd_rise_en = st.rise_en;
    assign LINK.pvd_fall_en = st.fall_en;
    assign LINK.bor_level = st.bor_level;
    assign LINK.inrush_wr = st.inrush_wr;
    assign LINK.inrush_data = st.inrush_data;

endmodule : sms_controller

// ==== logic/sms_device.sv ====
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module sms_device (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // digitised supply levels and converter clock monitor
    input wire logic [7:0] VDD_CODE_I,
    input wire logic [7:0] ANALOG_SUPPLY_CODE_I,
    input wire logic CONV_CLK_OK_I,
    // regulator enables and system reset
    output logic LDO_EN_O,
    output logic SMPS_EN_O,
    output logic SYS_RESET_O,
    // link to controller
    sms_link_if.device LINK
);

    typedef struct packed {
        sms_pkg::sms_supply_type sup;
        logic flag;
        logic [1:0] inrush;
        logic bor_rst;
        logic pvd_below;
        logic pvd_irq;
        logic pvd_wake;
        logic pvm_ok;
        logic end_of_life_level;
    } sms_dev_state_type;

    sms_dev_state_type st;
    sms_dev_state_type next_st;

    logic timer_start;
    logic timer_done;
    logic radio_active;
    logic radio_hold;
    logic low_off;
    logic smps_ok;
    logic want_smps;
    logic cur_smps;
    logic [2:0] bor_lvl;
    logic [2:0] pvd_lvl;
    logic [7:0] bor_low;
    logic [7:0] bor_high;
    logic below_pvd;

    // ==========================================================
    // settle timer for regulator hand-over
    sms_settle_timer sms_settle_timer_i (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(timer_start),
        .done_o(timer_done)
    );

    // ==========================================================
    // mode selection terms
    always_comb
    begin
        radio_active = (LINK.radio_mode == sms_pkg::RAD_ACTIVE);
        radio_hold = radio_active || (LINK.radio_mode == sms_pkg::RAD_STANDBY_XTAL);
        low_off = ((LINK.cpu_mode == sms_pkg::CPU_STOP1) ||
                   (LINK.cpu_mode == sms_pkg::CPU_STOP2) ||
                   (LINK.cpu_mode == sms_pkg::CPU_STANDBY) ||
                   (LINK.cpu_mode == sms_pkg::CPU_SHUTDOWN)) && !radio_active;
        // converter only with clock detection on and a live clock
        smps_ok = LINK.clk_detect_en && CONV_CLK_OK_I;
        cur_smps = (st.sup == sms_pkg::SUP_TO_SMPS) || (st.sup == sms_pkg::SUP_SMPS);
        if (radio_active)
            want_smps = LINK.radio_smps_cmd;
        else if (radio_hold)
            want_smps = cur_smps;
        else
            want_smps = LINK.cpu_select || LINK.radio_smps_cmd;
        want_smps = want_smps && smps_ok;
    end

    // ==========================================================
    // supervisor thresholds
    always_comb
    begin
        // lowest brownout level stays armed even in shutdown
        bor_lvl = (LINK.cpu_mode == sms_pkg::CPU_SHUTDOWN) ?
                  sms_pkg::LEVEL_LOWEST : LINK.bor_level;
        bor_low = sms_pkg::bor_threshold(bor_lvl);
        bor_high = bor_low + sms_pkg::BOR_HYST;
        // in standby the detector drops to its lowest level
        pvd_lvl = (LINK.cpu_mode == sms_pkg::CPU_STANDBY) ?
                  sms_pkg::LEVEL_LOWEST : LINK.pvd_level;
        below_pvd = VDD_CODE_I < sms_pkg::pvd_threshold(pvd_lvl);
    end

    // ==========================================================
    // next state
    always_comb
    begin
        next_st = st;
        timer_start = 1'b0;
        case (st.sup)
            sms_pkg::SUP_OFF:
            begin
                // wake-up restores the selection through the regulator
                if (!low_off)
                    next_st.sup = sms_pkg::SUP_LDO;
            end
            sms_pkg::SUP_LDO:
            begin
                if (low_off)
                    next_st.sup = sms_pkg::SUP_OFF;
                else if (want_smps)
                begin
                    next_st.sup = sms_pkg::SUP_TO_SMPS;
                    timer_start = 1'b1;
                end
            end
            sms_pkg::SUP_TO_SMPS:
            begin
                if (low_off)
                    next_st.sup = sms_pkg::SUP_OFF;
                else if (!smps_ok || !want_smps)
                    next_st.sup = sms_pkg::SUP_LDO;
                else if (timer_done)
                    next_st.sup = sms_pkg::SUP_SMPS;
            end
            sms_pkg::SUP_SMPS:
            begin
                if (low_off)
                    next_st.sup = sms_pkg::SUP_OFF;
                else if (!smps_ok)
                    next_st.sup = sms_pkg::SUP_LDO;
                else if (!want_smps)
                begin
                    next_st.sup = sms_pkg::SUP_TO_LDO;
                    timer_start = 1'b1;
                end
            end
            sms_pkg::SUP_TO_LDO:
            begin
                if (low_off)
                    next_st.sup = sms_pkg::SUP_OFF;
                else if (!smps_ok || timer_done)
                    next_st.sup = sms_pkg::SUP_LDO;
            end
            default:
                next_st.sup = sms_pkg::SUP_LDO;
        endcase
        // flag follows only completed hand-overs
        next_st.flag = (next_st.sup == sms_pkg::SUP_SMPS) ||
                       (next_st.sup == sms_pkg::SUP_TO_LDO);

        if (LINK.radio_mode == sms_pkg::RAD_DEEP_SLEEP)
            next_st.inrush = sms_pkg::INRUSH_RESET;
        else if (LINK.inrush_wr)
            next_st.inrush = LINK.inrush_data;

        if (VDD_CODE_I < bor_low)
            next_st.bor_rst = 1'b1;
        else if (VDD_CODE_I > bor_high)
            next_st.bor_rst = 1'b0;

        next_st.pvd_below = LINK.pvd_enable && below_pvd;
        next_st.pvd_irq = LINK.pvd_enable &&
            ((below_pvd && !st.pvd_below && LINK.pvd_fall_en) ||
             (!below_pvd && st.pvd_below && LINK.pvd_rise_en));
        next_st.pvd_wake = LINK.pvd_enable && below_pvd && !st.pvd_below;
        next_st.pvm_ok = ANALOG_SUPPLY_CODE_I >= sms_pkg::PVM_THR;
        next_st.end_of_life_level = VDD_CODE_I < sms_pkg::EOL_THR;
    end

    // ==========================================================
    // state register
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st <= '0;
            st.sup <= sms_pkg::SUP_LDO;
            st.inrush <= sms_pkg::INRUSH_RESET;
            st.bor_rst <= 1'b1;
            st.pvm_ok <= 1'b0;
        end
        else
            st <= next_st;
    end

    // ==========================================================
    // outputs
    assign LDO_EN_O = (st.sup != sms_pkg::SUP_OFF);
    assign SMPS_EN_O = (st.sup == sms_pkg::SUP_TO_SMPS) ||
                       (st.sup == sms_pkg::SUP_SMPS) ||
                       (st.sup == sms_pkg::SUP_TO_LDO);
    assign SYS_RESET_O = st.bor_rst;
    assign LINK.smps_active_flag = st.flag;
    assign LINK.ldo_on = LDO_EN_O;
    assign LINK.smps_on = SMPS_EN_O;
    assign LINK.bor_reset = st.bor_rst;
    assign LINK.pvd_irq = st.pvd_irq;
    assign LINK.pvd_wake = st.pvd_wake;
    assign LINK.pvm_ok = st.pvm_ok;
    assign LINK.end_of_life_level = st.end_of_life_level;
    assign LINK.inrush_value = st.inrush;

endmodule : sms_device

// ==== logic/sms_link_if.sv ====
`timescale 1ns/1ns
interface sms_link_if;
    // controller to device
    logic cpu_select;
    sms_pkg::sms_cpu_mode_type cpu_mode;
    sms_pkg::sms_radio_mode_type radio_mode;
    logic radio_smps_cmd;
    logic clk_detect_en;
    logic [2:0] bor_level;
    logic pvd_enable;
    logic [2:0] pvd_level;
    logic pvd_rise_en;
    logic pvd_fall_en;
    logic inrush_wr;
    logic [1:0] inrush_data;
    // device to controller
    logic smps_active_flag;
    logic ldo_on;
    logic smps_on;
    logic bor_reset;
    logic pvd_irq;
    logic pvd_wake;
    logic pvm_ok;
    logic end_of_life_level;
    logic [1:0] inrush_value;

    modport device (
        input cpu_select, cpu_mode, radio_mode, radio_smps_cmd, clk_detect_en,
        input bor_level, pvd_enable, pvd_level, pvd_rise_en, pvd_fall_en,
        input inrush_wr, inrush_data,
        output smps_active_flag, ldo_on, smps_on, bor_reset, pvd_irq,
        output pvd_wake, pvm_ok, end_of_life_level, inrush_value
    );

    modport controller (
        output cpu_select, cpu_mode, radio_mode, radio_smps_cmd, clk_detect_en,
        output bor_level, pvd_enable, pvd_level, pvd_rise_en, pvd_fall_en,
        output inrush_wr, inrush_data,
        input smps_active_flag, ldo_on, smps_on, bor_reset, pvd_irq,
        input pvd_wake, pvm_ok, end_of_life_level, inrush_value
    );
endinterface : sms_link_if

// ==== logic/sms_pkg.sv ====
package sms_pkg;

    // ==========================================================
    // operating modes
    typedef enum logic [2:0] {
        CPU_RUN,
        CPU_SLEEP,
        CPU_STOP0,
        CPU_STOP1,
        CPU_STOP2,
        CPU_STANDBY,
        CPU_SHUTDOWN
    } sms_cpu_mode_type;

    typedef enum logic [2:0] {
        RAD_DEEP_SLEEP,
        RAD_SLEEP,
        RAD_CALIBRATE,
        RAD_STANDBY,
        RAD_STANDBY_XTAL,
        RAD_ACTIVE
    } sms_radio_mode_type;

    typedef enum logic [2:0] {
        SUP_OFF,
        SUP_LDO,
        SUP_TO_SMPS,
        SUP_SMPS,
        SUP_TO_LDO
    } sms_supply_type;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_TIME_NS = 2000;
    localparam logic [8:0] SETTLE_CYCLES =
        9'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // supply level codes
    localparam logic [5:0][7:0] BOR_THR = {
        8'hd0, 8'hc4, 8'hb8, 8'had, 8'ha2, 8'h8c
    };
    localparam logic [7:0] BOR_HYST = 8'h04;
    localparam logic [7:0][7:0] PVD_THR = {
        8'hd8, 8'hcc, 8'hc0, 8'hb4, 8'ha8, 8'h9c, 8'h94, 8'h90
    };
    localparam logic [7:0] PVM_THR = 8'h7a;
    localparam logic [7:0] EOL_THR = 8'h8e;
    localparam logic [2:0] LEVEL_LOWEST = 3'h0;
    localparam logic [1:0] INRUSH_RESET = 2'h0;

    // ==========================================================
    // controller register map
    localparam logic [7:0] ADDR_POWER_CONTROL_FIVE = 8'h00;
    localparam logic [7:0] ADDR_POWER_CONTROL_THREE = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_INRUSH = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVENT = 8'h14;

    function automatic logic [7:0] bor_threshold(input logic [2:0] lvl);
        return (lvl > 3'h5) ? BOR_THR[5] : BOR_THR[lvl];
    endfunction : bor_threshold

    function automatic logic [7:0] pvd_threshold(input logic [2:0] lvl);
        return PVD_THR[lvl];
    endfunction : pvd_threshold

endpackage : sms_pkg

// ==== logic/sms_settle_timer.sv ====
`timescale 1ns/1ns
module sms_settle_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic start_i,
    output logic done_o
);

    typedef struct packed {
        logic busy;
        logic [8:0] count;
        logic done;
    } sms_timer_state_type;

    sms_timer_state_type st;
    sms_timer_state_type next_st;

    // ==========================================================
    // countdown
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        if (start_i)
        begin
            next_st.busy = 1'b1;
            next_st.count = sms_pkg::SETTLE_CYCLES;
        end
        else if (st.busy)
        begin
            next_st.count = st.count - 9'h001;
            if (st.count == 9'h001)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign done_o = st.done;

endmodule : sms_settle_timer

// ==== tb/sms_supply_properties.sv ====
`timescale 1ns/1ns
module sms_supply_properties (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CONV_CLK_OK_I,
    // link signals
    input wire logic cpu_select,
    input wire sms_pkg::sms_cpu_mode_type cpu_mode,
    input wire sms_pkg::sms_radio_mode_type radio_mode,
    input wire logic radio_smps_cmd,
    input wire logic clk_detect_en,
    input wire logic inrush_wr,
    input wire logic [1:0] inrush_data,
    input wire logic smps_active_flag,
    input wire logic ldo_on,
    input wire logic smps_on,
    input wire logic [1:0] inrush_value
);
    // ==========================================================
    // supply selection
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    reset_ldo_a: assert property ($fell(RST_I) |-> ldo_on && !smps_on && !smps_active_flag)
        else $error("supply not in regulator mode after reset");
    lowpower_off_a: assert property ((cpu_mode inside {sms_pkg::CPU_STOP1,
        sms_pkg::CPU_STOP2, sms_pkg::CPU_STANDBY}) && radio_mode != sms_pkg::RAD_ACTIVE
        |=> !ldo_on && !smps_on) else $error("supplies left on in low-power mode");
    radio_hold_a: assert property (radio_mode == sms_pkg::RAD_STANDBY_XTAL
        && $past(radio_mode) == sms_pkg::RAD_STANDBY_XTAL && cpu_mode == sms_pkg::CPU_RUN
        && !smps_on |=> !smps_on) else $error("mode changed while radio busy");
    mode_prec_a: assert property ($stable(radio_mode) && radio_mode == sms_pkg::RAD_SLEEP
        && $stable(cpu_mode) && cpu_mode == sms_pkg::CPU_RUN && (cpu_select || radio_smps_cmd)
        && clk_detect_en && CONV_CLK_OK_I && ldo_on && !smps_on |=> smps_on)
        else $error("converter request not taken");
    radio_ovr_a: assert property (radio_mode == sms_pkg::RAD_ACTIVE && $stable(radio_mode)
        && cpu_mode == sms_pkg::CPU_RUN && !radio_smps_cmd && !smps_on |=> !smps_on)
        else $error("radio regulator command not honoured");
    clk_fallback_a: assert property (!clk_detect_en || !CONV_CLK_OK_I
        |=> !smps_on && !smps_active_flag) else $error("converter on without clock");
    flag_settle_a: assert property ($rose(smps_active_flag) |-> smps_on && $past(smps_on, 250))
        else $error("flag set before switch completed");
    inrush_load_a: assert property (inrush_wr && radio_mode != sms_pkg::RAD_DEEP_SLEEP
        |=> inrush_value == $past(inrush_data)) else $error("inrush setting not loaded");
    inrush_keep_a: assert property (!inrush_wr && radio_mode != sms_pkg::RAD_DEEP_SLEEP
        |=> $stable(inrush_value)) else $error("inrush setting lost");
    inrush_lost_a: assert property (radio_mode == sms_pkg::RAD_DEEP_SLEEP
        |=> inrush_value == sms_pkg::INRUSH_RESET) else $error("inrush kept in deep sleep");
endmodule : sms_supply_properties

// ==== tb/supply_mode_and_supervisor_tb_top.sv ====
`timescale 1ns/1ns
module supply_mode_and_supervisor_tb_top;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] vdd;
    logic [7:0] analog_supply;
    logic clk_ok;
    logic serr;
    logic ldo_en;
    logic smps_en;
    logic sys_rst;
    int mismatches = 0;
    int total_checks = 0;

    // ==========================================================
    // design and checker
    sms_link_if sms_link_if_i ();
    sms_device sms_device_i (.CLK_I(clk), .RST_I(rst), .VDD_CODE_I(vdd), .ANALOG_SUPPLY_CODE_I(analog_supply),
        .CONV_CLK_OK_I(clk_ok), .LDO_EN_O(ldo_en), .SMPS_EN_O(smps_en),
        .SYS_RESET_O(sys_rst), .LINK(sms_link_if_i));
    sms_controller sms_controller_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(sms_link_if_i));
    sms_supply_properties sms_supply_properties_i (.CLK_I(clk), .RST_I(rst),
        .CONV_CLK_OK_I(clk_ok), .cpu_select(sms_link_if_i.cpu_select),
        .cpu_mode(sms_link_if_i.cpu_mode), .radio_mode(sms_link_if_i.radio_mode),
        .radio_smps_cmd(sms_link_if_i.radio_smps_cmd), .clk_detect_en(sms_link_if_i.clk_detect_en),
        .inrush_wr(sms_link_if_i.inrush_wr), .inrush_data(sms_link_if_i.inrush_data),
        .smps_active_flag(sms_link_if_i.smps_active_flag), .ldo_on(sms_link_if_i.ldo_on),
        .smps_on(sms_link_if_i.smps_on), .inrush_value(sms_link_if_i.inrush_value));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // bus and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rc

    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rc(sms_pkg::ADDR_STATUS, m, e);
    endtask : st

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic end_of_test();
        $display("mismatches %0d total_checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // scenarios
    task automatic t_reset();
        st(32'h3f, 32'h12);
        rc(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'hffffffff, 32'h0);
        rc(sms_pkg::ADDR_MODE, 32'hffffffff, 32'h10);
        rc(8'h18, 32'hffffffff, 32'h0);
        chk({31'h0, serr}, 32'h1);
    endtask : t_reset

    task automatic t_hold();
        wr(sms_pkg::ADDR_MODE, 32'h40);
        wr(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'h3);
        wt(5);
        st(32'h4, 32'h0);
        wr(sms_pkg::ADDR_MODE, 32'h30);
        wt(3);
        st(32'h5, 32'h4);
        wt(250);
        st(32'h5, 32'h5);
        clk_ok <= 1'b0;
        wt(2);
        st(32'h5, 32'h0);
        clk_ok <= 1'b1;
        wr(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'h2);
        wt(300);
        st(32'h5, 32'h0);
    endtask : t_hold

    task automatic t_prec();
        wr(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'h6);
        wt(3);
        st(32'h4, 32'h4);
        wr(sms_pkg::ADDR_MODE, 32'h50);
        wr(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'h3);
        wt(300);
        st(32'h5, 32'h0);
        wr(sms_pkg::ADDR_MODE, 32'h10);
        wt(3);
        st(32'h4, 32'h4);
        wt(260);
    endtask : t_prec

    task automatic t_lowpower();
        int m;
        for (m = 3; m <= 6; m++)
        begin
            wr(sms_pkg::ADDR_MODE, 32'h10 + 32'(m));
            wt(2);
            st(32'h6, 32'h0);
            chk({30'h0, ldo_en, smps_en}, 32'h0);
            rc(sms_pkg::ADDR_POWER_CONTROL_FIVE, 32'h1, 32'h1);
            wr(sms_pkg::ADDR_MODE, 32'h10);
            wt(5);
            st(32'h4, 32'h4);
        end
    endtask : t_lowpower

    task automatic t_inrush();
        wr(sms_pkg::ADDR_INRUSH, 32'h2);
        wr(sms_pkg::ADDR_MODE, 32'h30);
        rc(sms_pkg::ADDR_INRUSH, 32'h3, 32'h2);
        wr(sms_pkg::ADDR_MODE, 32'h0);
        rc(sms_pkg::ADDR_INRUSH, 32'h3, 32'h0);
        wr(sms_pkg::ADDR_MODE, 32'h10);
    endtask : t_inrush

    task automatic t_detector();
        wr(sms_pkg::ADDR_POWER_CONTROL_THREE, 32'h7);
        vdd <= 8'h8f;
        wt(5);
        rc(sms_pkg::ADDR_EVENT, 32'h3, 32'h3);
        wr(sms_pkg::ADDR_EVENT, 32'h3);
        rc(sms_pkg::ADDR_EVENT, 32'h3, 32'h0);
        vdd <= 8'hc0;
        wt(5);
        rc(sms_pkg::ADDR_EVENT, 32'h3, 32'h1);
        wr(sms_pkg::ADDR_EVENT, 32'h3);
        wr(sms_pkg::ADDR_POWER_CONTROL_THREE, 32'h3);
        vdd <= 8'h8f;
        wt(5);
        rc(sms_pkg::ADDR_EVENT, 32'h3, 32'h2);
        vdd <= 8'hc0;
        wt(5);
        rc(sms_pkg::ADDR_EVENT, 32'h3, 32'h3);
        wr(sms_pkg::ADDR_EVENT, 32'h3);
    endtask : t_detector

    task automatic t_levels();
        vdd <= 8'h8d;
        wt(3);
        st(32'h28, 32'h20);
        wr(sms_pkg::ADDR_MODE, 32'h50);
        wt(2);
        rc(sms_pkg::ADDR_MODE, 32'h70, 32'h10);
        vdd <= 8'h80;
        wt(3);
        st(32'h8, 32'h8);
        chk({31'h0, sys_rst}, 32'h1);
        vdd <= 8'h8e;
        wt(3);
        st(32'h8, 32'h8);
        vdd <= 8'h91;
        wt(3);
        st(32'h28, 32'h0);
        wr(sms_pkg::ADDR_POWER_CONTROL_THREE, 32'h200);
        vdd <= 8'ha0;
        wt(3);
        st(32'h8, 32'h8);
        vdd <= 8'hc0;
        analog_supply <= 8'h79;
        wt(3);
        st(32'h18, 32'h0);
        analog_supply <= 8'h7a;
        wt(3);
        st(32'h10, 32'h10);
    endtask : t_levels

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        vdd = 8'hc0;
        analog_supply = 8'h80;
        clk_ok = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_hold();
        t_prec();
        t_lowpower();
        t_inrush();
        t_detector();
        t_levels();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : supply_mode_and_supervisor_tb_top
